/* File: logic/sdc_dev_end.sv */
// Device end: one 8-bit stage of the daisy chain
`timescale 1ns/1ps
`include "sdc_map.svh"
module sdc_dev_end
	import sdc_pkg::*;
(
	input  wire logic  ref_clk,
	input  wire logic  rst_b,
	sdc_if.dev         link,
	input  wire sdc_byte_t diagIn,
	output sdc_byte_t  rxData,
	output logic       rxValid
);
	sdc_byte_t shiftReg;
	sdc_byte_t diagHold;
	logic [2:0] bitCnt;
	logic       started;
	logic       bitsOk;
	logic       frameTog;
	logic       csSync;
	logic       csPrev;
	logic       togSync;
	logic       lastTog;

	// Frame state dies with chip select high; no link edge comes then
	wire logic       frameRst  = link.csN | ~rst_b;
	wire logic [2:0] next_bitCnt = started ? 3'(bitCnt + 3'h1) : 3'h1;
	// Select end: the synced select level drops
	wire logic       csRise    = ~csSync & csPrev;
	// Shift word and count are static while chip select is high
	wire logic       accept    = csRise & bitsOk & (togSync != lastTog);

	always_ff @(negedge link.sclk or posedge frameRst) begin
		if (frameRst) begin
			started <= 1'b0;
		end else begin
			started <= 1'b1;
		end
	end

	always_ff @(negedge link.sclk or negedge rst_b) begin
		if (!rst_b) begin
			shiftReg <= 8'h00;
			bitCnt   <= 3'h0;
			bitsOk   <= 1'b0;
			frameTog <= 1'b0;
		end else if (!link.csN) begin
			shiftReg <= started ? {shiftReg[6:0], link.si} : {diagHold[6:0], link.si};
			bitCnt   <= next_bitCnt;
			bitsOk   <= (next_bitCnt == 3'h0);
			frameTog <= started ? frameTog : ~frameTog;
		end
	end

	always_ff @(posedge link.sclk or posedge frameRst) begin
		if (frameRst) begin
			link.soOe <= 1'b0;
			link.so   <= 1'b0;
		end else begin
			link.soOe <= 1'b1;
			link.so   <= started ? shiftReg[7] : diagHold[7];
		end
	end

	sdc_sync uCsSync (
		.clk   (ref_clk),
		.rst_b (rst_b),
		.din   (~link.csN),
		.dout  (csSync)
	);

	sdc_sync uTogSync (
		.clk   (ref_clk),
		.rst_b (rst_b),
		.din   (frameTog),
		.dout  (togSync)
	);

	// Diagnosis follows its input only while deselected, so a frame sees one byte
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			csPrev   <= 1'b0;
			lastTog  <= 1'b0;
			diagHold <= `SDC_DIAG_RST;
		end else begin
			csPrev   <= csSync;
			lastTog  <= csRise ? togSync : lastTog;
			diagHold <= csSync ? diagHold : diagIn;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxData  <= 8'h00;
			rxValid <= 1'b0;
		end else begin
			rxValid <= accept;
			rxData  <= accept ? shiftReg : rxData;
		end
	end
endmodule

/* File: logic/sdc_host_end.sv */
// Host end: bus master that clocks a whole daisy chain in one frame
`timescale 1ns/1ps
`include "sdc_map.svh"
// What the link does across host and device ends
// - One shared active-low select for all devices
// - Each input wired to neighbour's output
// - Master feeds first, reads last device
// - Master makes one clock for all
// - Device shifts one input bit per clock
// - Device outputs bit leaving its register
// - One device frame is eight clocks
// - Select rises after frame; word taken then
// - Master clocks eight bits per device
// - Select high at least 200 ns
// - Stretch gap to 200 us for diagnosis
// - Sample on falling, change on rising, MSB first
// - Accept only whole multiples of eight bits
// - Select fall freezes diagnosis; first falling clock loads it into register
// - Select high: ignore inputs, output released
module sdc_host_end
	import sdc_pkg::*;
#(
	parameter int unsigned DIAG_CYC = `SDC_DIAG_CYC
)
(
	input  wire logic      ref_clk,
	input  wire logic      rst_b,
	sdc_if.host            link,
	input  wire logic      start,
	input  wire sdc_word_t txWord,
	input  wire logic      longGap,
	output logic           busy,
	output logic           done,
	output sdc_word_t      rxWord
);
	localparam sdc_tmr_t HALF_LOAD = sdc_tmr_t'(`SDC_HALF_CYC - 1);
	localparam sdc_tmr_t LEAD_LOAD = sdc_tmr_t'(`SDC_LEAD_CYC - 1);
	localparam sdc_tmr_t LAG_LOAD  = sdc_tmr_t'(`SDC_LAG_CYC - 1);
	localparam sdc_tmr_t GAP_LOAD  = sdc_tmr_t'(`SDC_GAP_CYC - 1);
	localparam sdc_tmr_t DIAG_LOAD = sdc_tmr_t'(DIAG_CYC - 1);
	localparam logic [4:0] LAST_BIT = 5'(`SDC_FRAME_BITS - 1);

	sdc_hstate_e state;
	sdc_hstate_e next_state;
	sdc_tmr_t    tmr;
	sdc_tmr_t    next_tmr;
	logic [4:0]  bitCnt;
	sdc_word_t   txShift;
	sdc_word_t   rxShift;
	logic        gapLong;
	logic        misoSync;

	// Read-back from the last device is asynchronous to ref_clk
	sdc_sync uMisoSync (
		.clk   (ref_clk),
		.rst_b (rst_b),
		.din   (link.soWire),
		.dout  (misoSync)
	);

	wire logic tmrZero   = (tmr == 16'h0000);
	wire logic lastBit   = (bitCnt == LAST_BIT);
	wire logic inIdle    = (state == H_IDLE);
	wire logic inLead    = (state == H_LEAD);
	wire logic inHigh    = (state == H_HIGH);
	wire logic inLow     = (state == H_LOW);
	wire logic inLag     = (state == H_LAG);
	// A start while busy is dropped, so the select gap is never cut short
	wire logic takeStart = inIdle & start;
	wire logic riseEdge  = tmrZero & (inLead | inLow);
	wire logic fallEdge  = tmrZero & inHigh;
	wire logic endFrame  = tmrZero & inLag;
	wire sdc_tmr_t gapLoad   = gapLong ? DIAG_LOAD : GAP_LOAD;
	wire sdc_tmr_t countDown = tmrZero ? 16'h0000 : sdc_tmr_t'(tmr - 16'h0001);

	always_comb begin
		next_state = state;
		unique case (state)
			H_IDLE: begin
				if (start) begin
					next_state = H_LEAD;
				end
			end
			H_LEAD: begin
				if (tmrZero) begin
					next_state = H_HIGH;
				end
			end
			H_HIGH: begin
				if (tmrZero) begin
					next_state = lastBit ? H_LAG : H_LOW;
				end
			end
			H_LOW: begin
				if (tmrZero) begin
					next_state = H_HIGH;
				end
			end
			H_LAG: begin
				if (tmrZero) begin
					next_state = H_GAP;
				end
			end
			H_GAP: begin
				if (tmrZero) begin
					next_state = H_IDLE;
				end
			end
			// Two state codes are unused; a stray one falls back to idle
			default: begin
				next_state = H_IDLE;
			end
		endcase
	end

	always_comb begin
		next_tmr = countDown;
		if (takeStart) begin
			next_tmr = LEAD_LOAD;
		end else if (riseEdge) begin
			next_tmr = HALF_LOAD;
		end else if (fallEdge) begin
			next_tmr = lastBit ? LAG_LOAD : HALF_LOAD;
		end else if (endFrame) begin
			next_tmr = gapLoad;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= H_IDLE;
			tmr   <= 16'h0000;
		end else begin
			state <= next_state;
			tmr   <= next_tmr;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
		end else begin
			busy <= (next_state != H_IDLE);
		end
	end

	// One select for every device of the chain
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			link.csN <= 1'b1;
		end else if (takeStart) begin
			link.csN <= 1'b0;
		end else if (endFrame) begin
			link.csN <= 1'b1;
		end
	end

	// Divided clock; low whenever select changes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			link.sclk <= 1'b0;
		end else if (riseEdge) begin
			link.sclk <= 1'b1;
		end else if (fallEdge) begin
			link.sclk <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			gapLong <= 1'b0;
		end else if (takeStart) begin
			gapLong <= longGap;
		end
	end

	// MSB is set as select falls; later outgoing bits change on the rising clock edge
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			txShift <= 24'h000000;
			link.si <= 1'b0;
		end else if (takeStart) begin
			txShift <= txWord;
			link.si <= txWord[23];
		end else if (riseEdge & inLow) begin
			txShift <= {txShift[22:0], 1'b0};
			link.si <= txShift[22];
		end
	end

	// Returning bits are taken at the falling clock edge
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxShift <= 24'h000000;
			bitCnt  <= 5'h00;
		end else if (takeStart) begin
			bitCnt  <= 5'h00;
		end else if (fallEdge) begin
			rxShift <= {rxShift[22:0], misoSync};
			bitCnt  <= 5'(bitCnt + 5'h01);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxWord <= 24'h000000;
			done   <= 1'b0;
		end else begin
			done   <= endFrame;
			rxWord <= endFrame ? rxShift : rxWord;
		end
	end
endmodule

/* File: logic/sdc_sync.sv */
// Two-flop synchroniser for one level
`timescale 1ns/1ps
module sdc_sync (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic din,
	output logic      dout
);
	logic meta;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

/* File: pkg/sdc_if.sv */
// Link between the bus master and one shift device
`timescale 1ns/1ps
interface sdc_if;
	logic csN;
	logic sclk;
	logic si;
	logic so;
	logic soOe;
	wire  soWire;

	// Released line reads high, as with a pull-up
	assign soWire = soOe ? so : 1'b1;

	modport host (
		output csN,
		output sclk,
		output si,
		input  soWire
	);

	modport dev (
		input  csN,
		input  sclk,
		input  si,
		output so,
		output soOe
	);
endinterface

/* File: pkg/sdc_map.svh */
// Timing counts, frame sizes and reset values for the daisy-chain shift link
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

`define SDC_REF_PS        5000
`define SDC_BYTE_BITS     8
`define SDC_CHAIN_LEN     3
`define SDC_FRAME_BITS    (`SDC_CHAIN_LEN * `SDC_BYTE_BITS)
`define SDC_DIAG_RST      8'hFF

`define SDC_T_HALF_NS     100
`define SDC_T_LEAD_NS     250
`define SDC_T_LAG_NS      250
`define SDC_T_GAP_NS      200
`define SDC_T_DIAG_US     200

`define SDC_NS_TO_CYC(ns) (((ns) * 1000 + `SDC_REF_PS - 1) / `SDC_REF_PS)
`define SDC_HALF_CYC      `SDC_NS_TO_CYC(`SDC_T_HALF_NS)
`define SDC_LEAD_CYC      `SDC_NS_TO_CYC(`SDC_T_LEAD_NS)
`define SDC_LAG_CYC       `SDC_NS_TO_CYC(`SDC_T_LAG_NS)
`define SDC_GAP_CYC       `SDC_NS_TO_CYC(`SDC_T_GAP_NS)
`define SDC_DIAG_CYC      `SDC_NS_TO_CYC(`SDC_T_DIAG_US * 1000)

`endif

/* File: pkg/sdc_pkg.sv */
// Types shared by both ends of the daisy-chain shift link
package sdc_pkg;
	typedef logic [7:0]  sdc_byte_t;
	typedef logic [23:0] sdc_word_t;
	typedef logic [15:0] sdc_tmr_t;

	typedef enum logic [2:0] {
		H_IDLE,
		H_LEAD,
		H_HIGH,
		H_LOW,
		H_LAG,
		H_GAP
	} sdc_hstate_e;
endpackage

/* File: verif/sdc_checker.sv */
// Timing checks on the link between host and chain
`timescale 1ns/1ps
module sdc_checker (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic csN,
	input wire logic sclk,
	input wire logic si,
	input wire logic so,
	input wire logic soOe
);
	logic [15:0] hiCnt;
	logic [4:0]  bits;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// Cycles since select last moved; preset so the first frame passes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hiCnt <= 16'h0100;
			bits <= 5'h00;
		end else begin
			hiCnt <= $changed(csN) ? 16'h0000 : hiCnt + 16'h0001;
			bits <= csN ? 5'h00 : bits + {4'h0, $rose(sclk)};
		end
	end

	a_oe_released: assert property (csN && $past(csN) |-> !soOe)
		else $error("output driven while deselected");
	a_sclk_quiet: assert property ($changed(csN) |-> !sclk && !$past(sclk))
		else $error("clock high at select edge");
	a_gap_min: assert property ($fell(csN) |-> hiCnt >= 16'd39)
		else $error("select high gap too short");
	a_frame_bits: assert property ($rose(csN) |-> bits == 5'h18)
		else $error("frame not three bytes long");
	a_so_on_rise: assert property (!csN && $changed(so) |-> $rose(sclk))
		else $error("output moved off the rising clock");
	a_oe_first_rise: assert property ($rose(soOe) |-> $rose(sclk) && bits == 5'h00)
		else $error("output enabled at wrong time");
	a_si_stable: assert property ($fell(sclk) |-> $stable(si))
		else $error("data moved at falling clock");
	a_si_moves: assert property (!csN && !$past(csN) && $changed(si) |-> $rose(sclk))
		else $error("data moved off the rising clock");
endmodule

/* File: verif/spi_daisy_chain_shift_bench.sv */
// Host end clocking a chain of three device ends
`timescale 1ns/1ps
module spi_daisy_chain_shift_bench
	import sdc_pkg::*;
;
	logic      ref_clk;
	logic      rst_b;
	logic      start;
	logic      longGap;
	logic      busy;
	logic      done;
	sdc_word_t txWord;
	sdc_word_t rxWord;
	sdc_byte_t diag [3];
	sdc_byte_t rxData [3];
	logic      rxValid [3];
	sdc_byte_t got [3];
	int        hits [3] = '{0, 0, 0};
	int        frames = 0;
	int        errors = 0;
	int        checked = 0;

	sdc_if hA();
	sdc_if dl[3]();
	assign hA.so = dl[2].so;
	assign hA.soOe = dl[2].soOe;

	for (genvar i = 0; i < 3; i++) begin : g_dev
		assign dl[i].csN = hA.csN;
		assign dl[i].sclk = hA.sclk;
		if (i == 0) begin : g_first
			assign dl[i].si = hA.si;
		end else begin : g_next
			assign dl[i].si = dl[i-1].soWire;
		end
		sdc_dev_end sdc_dev_end_i (
			.ref_clk (ref_clk),
			.rst_b   (rst_b),
			.link    (dl[i]),
			.diagIn  (diag[i]),
			.rxData  (rxData[i]),
			.rxValid (rxValid[i])
		);
		always @(posedge ref_clk) begin
			if (rxValid[i] === 1'b1) begin
				got[i] <= rxData[i];
				hits[i] <= hits[i] + 1;
			end
		end
	end

	// Short diagnosis gap keeps the run brief
	sdc_host_end #(.DIAG_CYC(100)) sdc_host_end_i (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.link    (hA),
		.start   (start),
		.txWord  (txWord),
		.longGap (longGap),
		.busy    (busy),
		.done    (done),
		.rxWord  (rxWord)
	);

	sdc_checker sdc_checker_i (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.csN     (hA.csN),
		.sclk    (hA.sclk),
		.si      (hA.si),
		.so      (hA.so),
		.soOe    (hA.soOe)
	);

	task automatic print_verdict;
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// Bounded wait for done high or busy low
	task automatic wait_for(input bit forDone);
		int n;
		n = 0;
		while (forDone ? done !== 1'b1 : busy !== 1'b0) begin
			@(posedge ref_clk);
			#1;
			n++;
			if (n > 2000) begin
				errors++;
				print_verdict();
			end
		end
	endtask

	// One whole frame, then data and diagnosis compared per device
	task automatic frame(input sdc_word_t w, input logic lg);
		wait_for(1'b0);
		@(posedge ref_clk);
		txWord <= w;
		longGap <= lg;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		wait_for(1'b1);
		frames++;
		check(rxWord, {diag[2], diag[1], diag[0]});
		repeat (8) @(posedge ref_clk);
		#1;
		check({23'h0, hA.soWire}, 24'h1);
		check({got[2], got[1], got[0]}, w);
		for (int i = 0; i < 3; i++)
			check(hits[i][23:0], frames[23:0]);
	endtask

	task automatic test_chain;
		diag <= '{8'h81, 8'h42, 8'h3C};
		repeat (10) @(posedge ref_clk);
		frame(24'hA50FC3, 1'b0);
	endtask

	// Diagnosis changed in the gap, next frame at once
	task automatic test_diag_reload;
		@(posedge ref_clk);
		diag <= '{8'hE7, 8'h18, 8'h00};
		frame(24'h00FF5A, 1'b0);
	endtask

	task automatic test_long_gap;
		frame(24'hFF0001, 1'b1);
		repeat (80) @(posedge ref_clk);
		#1;
		check({23'h0, busy}, 24'h1);
		wait_for(1'b0);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial begin
		rst_b = 1'b0;
		start = 1'b0;
		longGap = 1'b0;
		txWord = '0;
		diag = '{8'hFF, 8'hFF, 8'hFF};
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		test_chain();
		test_diag_reload();
		test_long_gap();
		print_verdict();
	end
endmodule
